// [src/occ_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "occ_defs.svh"
module occ_core (
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   nrst,
   // Avalon-MM slave, word addressed
   input  wire logic [5:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   // Event inputs from other internal modules, asynchronous
   input  wire logic [20:0]            sync_src,
   input  wire logic [5:0]             clk_src,
   // Compare outputs and interrupt
   output logic      [4:0]             cmp_out,
   output logic                        irq
);
   localparam int N = `OCC_NUM_UNITS;

   typedef struct packed {
      occ_pkg::occ_cfg_t  [N-1:0] cfg;
      occ_pkg::occ_unit_t [N-1:0] u;
      logic [N-1:0]  run;
      logic [20:0]   sy1;
      logic [20:0]   sy2;
      logic [20:0]   sy3;
      logic [5:0]    ck1;
      logic [5:0]    ck2;
      logic [5:0]    ck3;
      logic [N-1:0]  stat;
      logic [N-1:0]  mask;
      logic [31:0]   rdata;
      logic          wait_n;
      logic [N-1:0]  outp;
      logic          irq;
   } occ_state_t;

   occ_state_t st_ff;
   occ_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////////
   // Sync source select: zero means no source; 1..21 pick a line.
   function automatic logic pick_sync(input logic [4:0] sel, input logic [20:0] ev);
      logic r;
      r = 1'b0;
      if (sel != `OCC_SYNC_FREE && sel <= 5'(`OCC_NUM_SYNC)) begin
         r = ev[sel - 5'h01];
      end
      return r;
   endfunction

   // Clock select: one of six rising-edge strobes, 6 and 7 read as idle.
   function automatic logic pick_clk(input logic [2:0] sel, input logic [5:0] ev);
      logic r;
      r = 1'b0;
      if (sel < 3'(`OCC_NUM_CLK)) begin
         r = ev[sel];
      end
      return r;
   endfunction

   // Cascade holds only while both halves of a pair set it.
   function automatic logic pair_on(input occ_pkg::occ_cfg_t a, input occ_pkg::occ_cfg_t b);
      return a.casc && b.casc;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [20:0]  sync_edge;
   logic [5:0]   clk_edge;
   logic [N-1:0] tick;
   logic [N-1:0] sync_hit;
   logic [N-1:0] wrap;
   logic [N-1:0] hi_of_pair;
   logic [N-1:0] ev;

   assign sync_edge = st_ff.sy2 & ~st_ff.sy3;
   assign clk_edge  = st_ff.ck2 & ~st_ff.ck3;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_unit
         // Even-indexed unit 0,2 is the odd-numbered low half; pairs 0/1 and 2/3.
         if (g % 2 == 1) begin : g_hi
            assign hi_of_pair[g] = pair_on(st_ff.cfg[g-1], st_ff.cfg[g]);
         end else begin : g_lo
            assign hi_of_pair[g] = 1'b0;
         end
         assign sync_hit[g] = pick_sync(st_ff.cfg[g].sync_sel, sync_edge);
         assign tick[g] = pick_clk(st_ff.cfg[g].clk_sel, clk_edge);
         assign wrap[g] = tick[g] && st_ff.u[g].cnt == 16'hffff;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [2:0]  reg_idx;
      logic [5:0]  unit_base;
      logic        hit;
      logic        up;
      logic [31:0] cnt32;
      logic [31:0] pri32;
      logic [31:0] sec32;
      logic        mpri;
      logic        msec;
      reg_idx   = 3'h0;
      unit_base = 6'h00;
      hit       = 1'b0;
      up        = 1'b0;
      cnt32     = 32'h0000_0000;
      pri32     = 32'h0000_0000;
      sec32     = 32'h0000_0000;
      mpri      = 1'b0;
      msec      = 1'b0;
      ev        = '0;
      nxt_st    = st_ff;

      nxt_st.sy1 = sync_src;
      nxt_st.sy2 = st_ff.sy1;
      nxt_st.sy3 = st_ff.sy2;
      nxt_st.ck1 = clk_src;
      nxt_st.ck2 = st_ff.ck1;
      nxt_st.ck3 = st_ff.ck2;

      // Counters and compare, one unit at a time.
      for (int i = 0; i < N; i++) begin
         if (hi_of_pair[i]) begin
            // High half counts on the low half's wrap and follows its run state.
            up = wrap[(i + N - 1) % N] && st_ff.run[(i + N - 1) % N];
            if (sync_hit[(i + N - 1) % N] && !st_ff.cfg[(i + N - 1) % N].trig) begin
               nxt_st.u[i].cnt = `OCC_RST_WORD;
            end else if (up) begin
               nxt_st.u[i].cnt = st_ff.u[i].cnt + 16'h0001;
            end
         end else begin
            if (st_ff.cfg[i].sync_sel == `OCC_SYNC_FREE) begin
               nxt_st.run[i] = 1'b1;
            end else if (st_ff.cfg[i].trig) begin
               if (sync_hit[i]) begin
                  nxt_st.run[i] = 1'b1;
               end
            end else begin
               nxt_st.run[i] = 1'b1;
            end
            if (sync_hit[i] && !st_ff.cfg[i].trig) begin
               nxt_st.u[i].cnt = `OCC_RST_WORD;
            end else if (tick[i] && st_ff.run[i]) begin
               nxt_st.u[i].cnt = st_ff.u[i].cnt + 16'h0001;
            end
         end
      end

      // Matches: a cascaded pair compares all 32 bits and drives the low unit's pin.
      for (int i = 0; i < N; i++) begin
         if (hi_of_pair[i]) begin
            ev[i] = 1'b0;
         end else begin
            if (i + 1 < N && hi_of_pair[(i + 1) % N]) begin
               cnt32 = {st_ff.u[(i + 1) % N].cnt, st_ff.u[i].cnt};
               pri32 = {st_ff.u[(i + 1) % N].pri, st_ff.u[i].pri};
               sec32 = {st_ff.u[(i + 1) % N].sec, st_ff.u[i].sec};
               mpri  = cnt32 == pri32;
               msec  = cnt32 == sec32;
            end else begin
               mpri = st_ff.u[i].cnt == st_ff.u[i].pri;
               msec = st_ff.u[i].cnt == st_ff.u[i].sec;
            end
            mpri = mpri && tick[i] && st_ff.run[i];
            msec = msec && tick[i] && st_ff.run[i];
            ev[i] = mpri || msec;
            case (st_ff.cfg[i].mode)
               occ_pkg::OCC_MODE_SINGLE: begin
                  if (mpri && !st_ff.u[i].done) begin
                     nxt_st.u[i].out = 1'b1;
                  end else if (msec && st_ff.u[i].out) begin
                     nxt_st.u[i].out  = 1'b0;
                     nxt_st.u[i].done = 1'b1;
                  end
               end
               occ_pkg::OCC_MODE_CONT: begin
                  if (mpri) begin
                     nxt_st.u[i].out = 1'b1;
                  end else if (msec) begin
                     nxt_st.u[i].out = 1'b0;
                  end
               end
               occ_pkg::OCC_MODE_PWM: begin
                  // Output rises at counter zero or on the secondary match and falls on the duty (primary) match.
                  if (mpri) begin
                     nxt_st.u[i].out = 1'b0;
                  end else if (msec || (st_ff.u[i].cnt == 16'h0000 && tick[i])) begin
                     nxt_st.u[i].out = 1'b1;
                  end
               end
               default: begin
                  nxt_st.u[i].out  = 1'b0;
                  nxt_st.u[i].done = 1'b0;
               end
            endcase
         end
         nxt_st.outp[i] = hi_of_pair[i] ? 1'b0 : nxt_st.u[i].out;
      end

      ////////////////////////////////////////////////////////////////////////
      // Bus slave: one wait cycle, answer on the second.
      hit = 1'b0;
      nxt_st.wait_n = 1'b0;
      nxt_st.rdata  = 32'h0000_0000;
      if ((avs_read || avs_write) && !st_ff.wait_n) begin
         nxt_st.wait_n = 1'b1;
         for (int i = 0; i < N; i++) begin
            unit_base = 6'(i) * 6'(`OCC_REG_STRIDE);
            if (avs_address >= unit_base && avs_address < unit_base + 6'h05) begin
               reg_idx = 3'(avs_address - unit_base);
               hit = 1'b1;
               case (reg_idx)
                  `OCC_REG_CTRL1: begin
                     nxt_st.rdata = {25'h0, st_ff.cfg[i].clk_sel, 1'b0, st_ff.cfg[i].mode};
                     if (avs_write) begin
                        nxt_st.cfg[i].mode    = occ_pkg::occ_mode_t'(avs_writedata[2:0]);
                        nxt_st.cfg[i].clk_sel = avs_writedata[6:4];
                        nxt_st.u[i].done      = 1'b0;
                     end
                  end
                  `OCC_REG_CTRL2: begin
                     nxt_st.rdata = {23'h0, st_ff.cfg[i].casc, st_ff.cfg[i].trig, 2'h0,
                                     st_ff.cfg[i].sync_sel};
                     if (avs_write) begin
                        nxt_st.cfg[i].sync_sel = avs_writedata[4:0];
                        nxt_st.cfg[i].trig     = avs_writedata[`OCC_C2_TRIG_BIT];
                        nxt_st.cfg[i].casc     = avs_writedata[`OCC_C2_CASC_BIT];
                        // Triggered mode re-arms: counter stops until the next event.
                        nxt_st.run[i] = 1'b0;
                     end
                  end
                  `OCC_REG_PRI: begin
                     nxt_st.rdata = {16'h0, st_ff.u[i].pri};
                     if (avs_write) begin
                        nxt_st.u[i].pri = avs_writedata[15:0];
                     end
                  end
                  `OCC_REG_SEC: begin
                     nxt_st.rdata = {16'h0, st_ff.u[i].sec};
                     if (avs_write) begin
                        nxt_st.u[i].sec = avs_writedata[15:0];
                     end
                  end
                  default: begin
                     nxt_st.rdata = {16'h0, st_ff.u[i].cnt};
                     if (avs_write) begin
                        nxt_st.u[i].cnt = avs_writedata[15:0];
                     end
                  end
               endcase
            end
         end
         if (avs_address == `OCC_ADDR_MASK) begin
            nxt_st.rdata = {27'h0, st_ff.mask};
            if (avs_write) begin
               nxt_st.mask = avs_writedata[N-1:0];
            end
         end
         // Write answers carry no data, so a stale register value never reaches the bus.
         if (avs_write) begin
            nxt_st.rdata = 32'h0000_0000;
         end
      end

      // Sticky events; a new event wins over the clearing read.
      if ((avs_read && !st_ff.wait_n) && avs_address == `OCC_ADDR_STATUS) begin
         nxt_st.rdata = {27'h0, st_ff.stat};
         nxt_st.stat  = ev;
      end else begin
         nxt_st.stat = st_ff.stat | ev;
      end
      nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign avs_readdata    = st_ff.rdata;
   assign avs_waitrequest = !st_ff.wait_n;
   assign cmp_out         = st_ff.outp;
   assign irq             = st_ff.irq;
endmodule
`default_nettype wire

// [shared/occ_defs.svh]
`ifndef OCC_DEFS_SVH
`define OCC_DEFS_SVH
// Summary of operation
// - Five independent compare units with pulse/PWM output
// - Single/continuous cascade as 32-bit; cascaded PWM rises at each low-half zero
// - Sync/trigger source chosen from 21 sources
// - Primary and secondary period compared with counter
// - Single pulse, continuous pulse or PWM output
// - Own 16-bit counter, one of six clocks
// - Free-running counter wraps all-ones to zero
// - Event whenever counter equals either period
// - Synchronous: sync event resets the counter
// - Triggered: counter held until sync event arrives
// - Sync field zero selects free-running operation
// - Bit seven set selects triggered, clear synchronous
// - Sync field picks the sync/trigger source
// - Odd unit low half, even unit high half
// - Low-half wrap increments the paired high half
// - Cascade only when both units set cascade bit

`define OCC_NUM_UNITS     5
`define OCC_NUM_SYNC      21
`define OCC_NUM_CLK       6

// Register word offsets (byte address = 4 * index).
`define OCC_REG_STRIDE    8'h08
`define OCC_REG_CTRL1     3'h0
`define OCC_REG_CTRL2     3'h1
`define OCC_REG_PRI       3'h2
`define OCC_REG_SEC       3'h3
`define OCC_REG_CNT       3'h4
`define OCC_ADDR_STATUS   6'h28
`define OCC_ADDR_MASK     6'h29

// Control-one fields: output mode and clock select.
`define OCC_C1_MODE_LSB   0
`define OCC_C1_CLK_LSB    4
// Control-two fields.
`define OCC_C2_SYNC_LSB   0
`define OCC_C2_TRIG_BIT   7
`define OCC_C2_CASC_BIT   8

`define OCC_SYNC_FREE     5'h00
`define OCC_RST_WORD      16'h0000
`endif

// [shared/occ_pkg.sv]
package occ_pkg;
   typedef enum logic [2:0] {
      OCC_MODE_OFF    = 3'h0,
      OCC_MODE_SINGLE = 3'h1,
      OCC_MODE_CONT   = 3'h2,
      OCC_MODE_PWM    = 3'h3
   } occ_mode_t;

   typedef struct packed {
      logic [2:0]  clk_sel;
      occ_mode_t   mode;
      logic        casc;
      logic        trig;
      logic [4:0]  sync_sel;
   } occ_cfg_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] pri;
      logic [15:0] sec;
      logic        armed;
      logic        done;
      logic        out;
   } occ_unit_t;

   typedef struct packed {
      logic [5:0]  addr;
      logic        rd;
      logic        wr;
      logic [31:0] wdata;
   } occ_req_t;
endpackage

// [testbench/occ_core_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module occ_core_properties (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        nrst,
   // Register bus
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Events and outputs
   input wire logic [20:0] sync_src,
   input wire logic [5:0]  clk_src,
   input wire logic [4:0]  cmp_out,
   input wire logic        irq
);
   ////////////////////////////////////////////////////////////////////////////////
   // Cycles since the last write or edge on any event line; outputs need a cause.
   logic [4:0]  quiet_ff;
   logic [4:0]  nxt_quiet;
   logic [26:0] lines_ff;
   always_comb begin
      nxt_quiet = (quiet_ff == 5'h1f) ? quiet_ff : quiet_ff + 5'h01;
      if (avs_write || {clk_src, sync_src} != lines_ff) begin
         nxt_quiet = 5'h00;
      end
   end
   always_ff @(posedge clk_sys) begin
      quiet_ff <= nrst ? nxt_quiet : 5'h00;
      lines_ff <= {clk_src, sync_src};
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_take;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_take_answer: assert property (s_take |=> s_answer)
      else $error("request not answered in one cycle");
   a_answer_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
      else $error("answer without request");
   a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
      else $error("answer while idle");
   a_rdata_zero: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
      else $error("read data outside answer");
   a_wr_silent: assert property (!avs_waitrequest && avs_write |-> avs_readdata == 32'h0)
      else $error("read data on write answer");
   a_reset_quiet: assert property ($rose(nrst) |-> cmp_out == 5'h00 && !irq && avs_waitrequest)
      else $error("outputs not idle after reset");
   a_irq_cause: assert property ($rose(irq) |-> quiet_ff < 5'd16)
      else $error("interrupt without event");
   a_cmp_frozen: assert property (quiet_ff >= 5'd16 |=> $stable(cmp_out))
      else $error("compare output moved without tick");
endmodule
bind occ_core occ_core_properties occ_core_properties_i (.clk_sys(clk_sys), .nrst(nrst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .sync_src(sync_src), .clk_src(clk_src),
   .cmp_out(cmp_out), .irq(irq));
`default_nettype wire

// [testbench/occ_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module occ_far_model (
   // Clock
   input wire logic         clk_sys,
   // Requested line levels
   input wire logic [5:0]   ck_pulse,
   input wire logic [20:0]  sy_pulse,
   // Lines into the block
   output logic      [5:0]  clk_src,
   output logic      [20:0] sync_src
);
   // Count clocks stand low between requested ticks, so counts are exact.
   always_ff @(posedge clk_sys) begin
      clk_src  <= ck_pulse;
      sync_src <= sy_pulse;
   end
endmodule
`default_nettype wire

// [testbench/test_occ_core.sv]
`timescale 1ns/1ps
`default_nettype none
module test_occ_core;
   logic clk_sys = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, irq, avs_waitrequest;
   logic [5:0] avs_address = 6'h00, clk_src, ck_pulse = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rv, c1;
   logic [20:0] sync_src, sy_pulse = 21'h0;
   logic [4:0] cmp_out;
   int fails = 0, num_checks = 0, seed = 71731;
   always #10 clk_sys = ~clk_sys;
   occ_core occ_core_i (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sync_src(sync_src), .clk_src(clk_src), .cmp_out(cmp_out), .irq(irq));
   occ_far_model occ_far_model_i (.clk_sys(clk_sys), .ck_pulse(ck_pulse),
      .sy_pulse(sy_pulse), .clk_src(clk_src), .sync_src(sync_src));
   ////////////////////////////////////////////////////////////////////////////////
   task summarize;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [5:0] ra(input int u, input int off);
      return 6'(u * 8 + off);
   endfunction
   // The request stays up until the edge that samples waitrequest low.
   task bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rv = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         fails++;
         summarize();
      end
   endtask
   task pulse(input logic ck, input int ln, input int n);
      repeat (n) begin
         if (ck) ck_pulse[ln] <= 1'b1; else sy_pulse[ln] <= 1'b1;
         repeat (4) @(posedge clk_sys);
         ck_pulse <= 6'h00;
         sy_pulse <= 21'h0;
         repeat (4) @(posedge clk_sys);
      end
      repeat (4) @(posedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clk_sys);
      fails++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int u = 0; u < 5; u++) begin
         bus(1, ra(u, 1), 0); chk("ctrl2", 32'h0, rv);
         for (int o = 2; o < 4; o++) begin
            c1 = $random(seed) & 32'hffff;
            bus(0, ra(u, o), c1); bus(1, ra(u, o), 0); chk("period", c1, rv);
         end
      end
      bus(1, 6'h3f, 0); chk("unmapped", 32'h0, rv);
      for (int k = 0; k < 6; k++) begin
         bus(0, ra(4, 0), k << 4); bus(0, ra(4, 4), 0); pulse(1, k, 3);
         bus(1, ra(4, 4), 0); chk("count", 32'h3, rv);
      end
      bus(0, ra(4, 4), 32'hffff); pulse(1, 5, 1);
      bus(1, ra(4, 4), 0); chk("wrap", 32'h0, rv);
      bus(0, ra(4, 2), 32'h2); bus(0, ra(4, 3), 32'h9); bus(0, 6'h29, 32'h10);
      bus(1, 6'h28, 0); pulse(1, 5, 3); chk("irq", 32'h1, irq);
      bus(1, 6'h28, 0); chk("status", 32'h10, rv & 32'h10);
      repeat (3) @(posedge clk_sys); chk("irq clear", 32'h0, irq);
      bus(0, 6'h29, 0); pulse(1, 5, 7); chk("irq masked", 32'h0, irq);
      bus(1, 6'h28, 0); chk("status sec", 32'h10, rv & 32'h10);
      bus(0, ra(4, 1), 32'h1); bus(0, ra(4, 4), 32'h5); pulse(0, 1, 1);
      bus(1, ra(4, 4), 0); chk("other source", 32'h5, rv);
      pulse(0, 0, 1); bus(1, ra(4, 4), 0); chk("sync reset", 32'h0, rv);
      pulse(1, 5, 1); bus(1, ra(4, 4), 0); chk("sync run", 32'h1, rv);
      bus(0, ra(4, 1), 32'h82); bus(0, ra(4, 4), 32'h7); pulse(1, 5, 2);
      bus(1, ra(4, 4), 0); chk("trig hold", 32'h7, rv);
      pulse(0, 1, 1); pulse(1, 5, 2); bus(1, ra(4, 4), 0);
      chk("trig run", 32'h9, rv);
      bus(0, ra(4, 1), 0); bus(1, ra(4, 4), 0); c1 = rv; pulse(1, 5, 1);
      bus(1, ra(4, 4), 0); chk("free again", c1 + 32'h1, rv);
      // Single, continuous and PWM output of unit 4 with primary 2 and secondary 9.
      for (int m = 1; m < 4; m++) begin
         bus(0, ra(4, 0), 32'h50 | m); bus(0, ra(4, 4), 0);
         pulse(1, 5, (m == 3) ? 1 : 3);
         chk("out rise", 32'h10, cmp_out);
         pulse(1, 5, (m == 3) ? 2 : 7);
         chk("out fall", 32'h0, cmp_out);
      end
      // A single pulse stays spent until control one is written again.
      bus(0, ra(4, 0), 32'h51); bus(0, ra(4, 4), 0); pulse(1, 5, 10);
      bus(0, ra(4, 4), 0); pulse(1, 5, 3);
      chk("single once", 32'h0, cmp_out);
      bus(0, ra(0, 0), 32'h50); bus(0, ra(1, 0), 32'h50); bus(0, ra(0, 1), 32'h100);
      bus(0, ra(0, 4), 32'hffff); bus(0, ra(1, 4), 0); pulse(1, 5, 1);
      bus(1, ra(1, 4), 0); chk("half pair", 32'h1, rv);
      bus(0, ra(1, 1), 32'h100); bus(0, ra(0, 4), 32'hffff); bus(0, ra(1, 4), 0);
      pulse(1, 5, 1); bus(1, ra(0, 4), 0); chk("low half", 32'h0, rv);
      bus(1, ra(1, 4), 0); chk("high half", 32'h1, rv);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      bus(1, ra(0, 1), 0); chk("ctrl2 again", 32'h0, rv);
      summarize();
   end
endmodule
`default_nettype wire
